// File: hw/fast_io_lane.sv
// Fast I/O lane: serializer, deserializer, delay chain with phase alignment,
// receive FIFO and a Wishbone register port, all on ref_clk.
// Assumes ref_clk is the serial bit rate; parallel rate is an enable pulse.
//
// The implementer's own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/100ps
module fast_io_lane
    import lane_pkg::*;
#(
    parameter int FIFO_DEPTH = 8,
    parameter int LOCK_WORDS = 4,
    parameter int CHANNEL_ID = 0,
    parameter int DATA_LANE_ID = 0
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Core transmit side
    input wire logic [9:0] tx_word,
    input wire logic tx_path_reset,
    // Core receive side
    output logic [9:0] rx_word,
    output logic [9:0] fifo_word,
    output logic fifo_empty,
    input wire logic fifo_rd,
    input wire logic rx_path_reset,
    output logic phase_lock,
    output logic [5:0] final_delay_setting,
    // Delay control
    input wire logic delay_adjust_enable,
    input wire logic delay_step_up,
    input wire logic delay_adjust_reset,
    // Differential pads
    input wire logic rx_pad_p,
    input wire logic rx_pad_n,
    output logic tx_pad_p,
    output logic tx_pad_n,
    output logic tx_pad_oe,
    output logic rx_buffer_on,
    output logic rx_term_on,
    // Clocks forwarded to data lanes
    output logic fwd_serial_en,
    output logic fwd_parallel_en
);
    localparam int AW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
    localparam int LW = $clog2(FIFO_DEPTH + 1);

    // Effective factor from the mode
    function automatic logic [3:0] eff_width(input ctrl_t c);
        logic [3:0] w;
        w = (c.width == 4'h0 || c.width > MAX_WIDTH) ? MAX_WIDTH : c.width;
        // High speed eight, low power one
        unique case (c.mode)
            MODE_MIPI_HS: eff_width = HS_WIDTH;
            MODE_MIPI_LP: eff_width = LP_WIDTH;
            MODE_LVDS: eff_width = w;
            default: eff_width = w;
        endcase
    endfunction : eff_width

    // First received bit lands in bit 0
    function automatic logic [9:0] align(input logic [9:0] sr, input logic [3:0] w);
        align = sr >> (MAX_WIDTH - w);
    endfunction : align

    // Half-ones pattern for the reference clock
    function automatic logic [9:0] clk_pattern(input logic [3:0] w);
        logic [3:0] half;
        half = (w + 4'h1) >> 1;
        clk_pattern = 10'h3ff >> (MAX_WIDTH - half);
    endfunction : clk_pattern

    // Byte-lane merge for writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        for (int i = 0; i < 4; i++) begin
            merge[8*i +: 8] = sel[i] ? nw[8*i +: 8] : old[8*i +: 8];
        end
    endfunction : merge

    ctrl_t ctrl_q; // Software control
    logic ack_q; // Bus answer
    logic [31:0] dat_q; // Read data
    logic [3:0] bit_cnt_q; // Bit position in word
    logic [3:0] w; // Shared factor
    logic par_en; // Parallel edge pulse
    logic [9:0] tx_sr_q; // Serializer
    logic [7:0] hist_q; // Delay chain samples
    logic rx_bit; // Buffered pad bit
    logic sample; // Delayed bit
    logic [9:0] rx_sr_q; // Deserializer
    logic [9:0] sr_d; // Deserializer next
    logic [9:0] word_d; // Aligned next word
    logic [9:0] rx_word_q; // Presented word
    logic [5:0] tap_q; // Delay tap
    align_state_t align_q; // Training state
    logic [3:0] stable_q; // Clean words seen
    logic [5:0] final_q; // Tap shown after lock
    logic [9:0] mem_q [FIFO_DEPTH]; // FIFO storage
    logic [AW-1:0] wr_q; // Write pointer
    logic [AW-1:0] rd_q; // Read pointer
    logic [LW-1:0] cnt_q; // Fill level
    logic [9:0] fifo_q; // Popped word
    logic push; // FIFO write
    logic pop; // FIFO read
    logic cfg_bad; // Lane set-up invalid
    status_t status; // Status view
    logic req; // New bus request

    // Bus request and status view
    assign req = wb_cyc_i && wb_stb_i && !ack_q;
    always_comb begin
        status = '0;
        status.lock = phase_lock;
        status.fifo_empty = fifo_empty;
        status.cfg_bad = cfg_bad;
        status.final_delay = final_q;
        status.fifo_level = 4'(cnt_q);
    end

    // Wishbone answer one cycle after the request
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
        end else begin
            ack_q <= req;
            if (req && !wb_we_i) begin
                unique case (wb_adr_i)
                    CTRL_OFS: dat_q <= ctrl_q;
                    STATUS_OFS: dat_q <= status;
                    default: dat_q <= 32'h00000000;
                endcase
            end
        end
    end

    // Control register writes
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= CTRL_RST;
        end else if (req && wb_we_i && wb_adr_i == CTRL_OFS) begin
            ctrl_q <= ctrl_t'(merge(ctrl_q, wb_dat_i, wb_sel_i) & 32'h0001ffff);
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    assign w = eff_width(ctrl_q);
    assign par_en = (bit_cnt_q >= w - 4'h1);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            bit_cnt_q <= 4'h0;
        end else if (par_en) begin
            bit_cnt_q <= 4'h0;
        end else begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
        end
    end

    // Serializer, LSB first
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tx_sr_q <= 10'h000;
        end else if (tx_path_reset) begin
            tx_sr_q <= 10'h000;
        end else if (par_en) begin
            tx_sr_q <= ctrl_q.tx_refclk ? clk_pattern(w) : (tx_word & (10'h3ff >> (MAX_WIDTH - w)));
        end else begin
            tx_sr_q <= tx_sr_q >> 1;
        end
    end

    assign tx_pad_p = tx_sr_q[0];
    assign tx_pad_n = ~tx_sr_q[0];
    assign tx_pad_oe = ctrl_q.tx_oe;

    assign rx_buffer_on = ctrl_q.buf_on;
    assign rx_term_on = ctrl_q.term_on;
    assign rx_bit = ctrl_q.buf_on && rx_pad_p && !rx_pad_n;

    // Delay chain: 8 fine taps per bit
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            hist_q <= 8'h00;
        end else begin
            hist_q <= {hist_q[6:0], rx_bit};
        end
    end
    always_comb begin
        sample = hist_q[tap_q[5:3]];
        sr_d = {sample, rx_sr_q[9:1]};
        word_d = align(sr_d, w);
    end

    // Deserializer and word output
    always_ff @(posedge ref_clk or negedge nrst or posedge rx_path_reset) begin
        if (!nrst || rx_path_reset) begin
            rx_sr_q <= 10'h000;
            rx_word_q <= 10'h000;
        end else begin
            rx_sr_q <= sr_d;
            if (par_en) begin
                rx_word_q <= word_d;
            end
        end
    end
    assign rx_word = rx_word_q;

    // Delay stepping and phase alignment
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tap_q <= 6'h00;
            align_q <= ALIGN_IDLE;
            stable_q <= 4'h0;
        end else if (par_en) begin
            if (delay_adjust_reset) begin
                tap_q <= 6'h00;
                align_q <= ALIGN_IDLE;
                stable_q <= 4'h0;
            end else if (!ctrl_q.align_en) begin
                align_q <= ALIGN_IDLE;
                if (delay_adjust_enable && delay_step_up && tap_q != TAP_MAX) begin
                    tap_q <= tap_q + 6'h01;
                end else if (delay_adjust_enable && !delay_step_up && tap_q != 6'h00) begin
                    tap_q <= tap_q - 6'h01;
                end
            end else if (delay_adjust_enable) begin
                unique case (align_q)
                    ALIGN_IDLE: begin
                        align_q <= ALIGN_TRAIN;
                        stable_q <= 4'h0;
                    end
                    ALIGN_TRAIN: begin
                        if (word_d != rx_word_q) begin
                            stable_q <= 4'h0;
                            tap_q <= tap_q + 6'h01;
                        end else if (stable_q == 4'(LOCK_WORDS - 1)) begin
                            align_q <= ALIGN_LOCKED;
                        end else begin
                            stable_q <= stable_q + 4'h1;
                        end
                    end
                    ALIGN_LOCKED: align_q <= ALIGN_LOCKED;
                    default: align_q <= ALIGN_IDLE;
                endcase
            end
        end
    end
    assign phase_lock = (align_q == ALIGN_LOCKED);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            final_q <= 6'h00;
        end else begin
            final_q <= phase_lock ? tap_q : 6'h00;
        end
    end
    assign final_delay_setting = final_q;

    // FIFO controls; no write while training
    assign push = par_en && ctrl_q.fifo_en && (!ctrl_q.align_en || phase_lock)
                  && (cnt_q != LW'(FIFO_DEPTH));
    assign pop = fifo_rd && (cnt_q != '0);

    // FIFO pointers and level
    always_ff @(posedge ref_clk or negedge nrst or posedge rx_path_reset) begin
        if (!nrst || rx_path_reset) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            fifo_q <= 10'h000;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(FIFO_DEPTH - 1)) ? '0 : wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(FIFO_DEPTH - 1)) ? '0 : rd_q + AW'(1);
                fifo_q <= mem_q[rd_q];
            end
            cnt_q <= cnt_q + LW'(push) - LW'(pop);
        end
    end

    // FIFO storage, no reset needed
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_q[wr_q] <= word_d;
        end
    end

    // Empty flag on the read side
    assign fifo_empty = (cnt_q == '0);
    assign fifo_word = fifo_q;

    always_comb begin
        cfg_bad = !(ctrl_q.lanes inside {4'h1, 4'h2, 4'h4, 4'h8});
        if (CHANNEL_ID >= RX_CHANNELS || DATA_LANE_ID >= LANES_PER_CHANNEL) begin
            cfg_bad = 1'b1;
        end
    end

    assign fwd_serial_en = ctrl_q.clk_lane && ctrl_q.mode == MODE_MIPI_HS && ctrl_q.buf_on;
    assign fwd_parallel_en = fwd_serial_en && par_en;

    // Checks
    a_rx_word_hold: assert property (@(posedge ref_clk) disable iff (!nrst || rx_path_reset)
        !par_en |=> $stable(rx_word_q)) else $error("rx word moved off parallel edge");
    a_tx_capture: assert property (@(posedge ref_clk) disable iff (!nrst)
        par_en && !tx_path_reset && !ctrl_q.tx_refclk && w == MAX_WIDTH
        |=> tx_sr_q == $past(tx_word)) else $error("tx word not captured");
    a_refclk_high: assert property (@(posedge ref_clk) disable iff (!nrst)
        par_en && !tx_path_reset && ctrl_q.tx_refclk |=> tx_pad_p) else $error("refclk not started high");
    a_word_period: assert property (@(posedge ref_clk) disable iff (!nrst)
        par_en && w == HS_WIDTH && $stable(w) |=> (!par_en || w != HS_WIDTH) [*7]
        ##1 (par_en || w != HS_WIDTH)) else $error("bad parallel period");
    a_tx_reset: assert property (@(posedge ref_clk) disable iff (!nrst)
        tx_path_reset |=> !tx_pad_p) else $error("tx reset ignored");
    a_lock_rise: assert property (@(posedge ref_clk) disable iff (!nrst)
        $rose(phase_lock) |-> $past(stable_q) == 4'(LOCK_WORDS - 1)) else $error("early lock");
    a_fifo_empty: assert property (@(posedge ref_clk) disable iff (!nrst)
        pop && cnt_q == LW'(1) && !push |=> fifo_empty) else $error("empty not raised");
    a_fifo_pop: assert property (@(posedge ref_clk) disable iff (!nrst || rx_path_reset)
        !fifo_rd |=> $stable(rd_q)) else $error("fifo advanced without read");
    a_rx_reset_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
        rx_path_reset |-> fifo_empty && rx_word == 10'h000) else $error("rx reset not clearing");
    a_buffer_off: assert property (@(posedge ref_clk) disable iff (!nrst)
        !ctrl_q.buf_on |=> !hist_q[0]) else $error("buffer off passed data");
    a_manual_up: assert property (@(posedge ref_clk) disable iff (!nrst)
        par_en && !ctrl_q.align_en && delay_adjust_enable && delay_step_up && !delay_adjust_reset
        && tap_q != TAP_MAX |=> tap_q == $past(tap_q) + 6'h01) else $error("tap did not step up");
    a_delay_reset: assert property (@(posedge ref_clk) disable iff (!nrst)
        par_en && delay_adjust_reset |=> tap_q == 6'h00 && !phase_lock) else $error("delay reset ignored");
    a_final_delay: assert property (@(posedge ref_clk) disable iff (!nrst)
        phase_lock |=> final_delay_setting == $past(tap_q)) else $error("final delay wrong");
    a_mipi_width: assert property (@(posedge ref_clk) disable iff (!nrst)
        ctrl_q.mode == MODE_MIPI_HS |-> w == HS_WIDTH) else $error("hs factor not eight");
    c_lock: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(phase_lock));
    c_fifo_full: cover property (@(posedge ref_clk) disable iff (!nrst) cnt_q == LW'(FIFO_DEPTH));
    c_refclk: cover property (@(posedge ref_clk) disable iff (!nrst) par_en && ctrl_q.tx_refclk);
    c_fwd: cover property (@(posedge ref_clk) disable iff (!nrst) fwd_parallel_en);
endmodule : fast_io_lane

// File: hw/lane_pkg.sv
// Shared constants, register layouts and mode codes for the fast I/O lane.
// Assumes a 32-bit classic Wishbone register port on a single clock.
package lane_pkg;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    // Serialization factors
    localparam logic [3:0] MAX_WIDTH = 4'ha;
    localparam logic [3:0] HS_WIDTH = 4'h8;
    localparam logic [3:0] LP_WIDTH = 4'h1;
    // Delay chain size and lane counts
    localparam logic [5:0] TAP_MAX = 6'h3f;
    localparam int RX_CHANNELS = 18;
    localparam int LANES_PER_CHANNEL = 8;
    // Lane use
    typedef enum logic [1:0] {
        MODE_LVDS = 2'b00,
        MODE_MIPI_HS = 2'b01,
        MODE_MIPI_LP = 2'b10
    } lane_mode_t;
    // Phase alignment training states
    typedef enum logic [1:0] {
        ALIGN_IDLE = 2'b00,
        ALIGN_TRAIN = 2'b01,
        ALIGN_LOCKED = 2'b10
    } align_state_t;
    // Control register layout
    typedef struct packed {
        logic [14:0] rsvd;
        logic tx_oe;
        logic buf_on;
        logic [3:0] lanes;
        logic [3:0] width;
        logic tx_refclk;
        logic clk_lane;
        lane_mode_t mode;
        logic fifo_en;
        logic align_en;
        logic term_on;
    } ctrl_t;
    // Status register layout
    typedef struct packed {
        logic [18:0] rsvd;
        logic [3:0] fifo_level;
        logic [5:0] final_delay;
        logic cfg_bad;
        logic fifo_empty;
        logic lock;
    } status_t;
    // Reset: width 10, one data lane
    localparam ctrl_t CTRL_RST = ctrl_t'(32'h00000d00);
endpackage : lane_pkg

// File: test/core_logic_model.sv
// Core logic model: presents transmit words and pops the receive FIFO.
// Assumes the lane's FIFO read side runs on ref_clk, as the lane does.
`timescale 1ns/100ps
module core_logic_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Commands from the bench
    input wire logic [9:0] word_req,
    input wire logic drain_req,
    input wire logic slow_rd,
    // Lane side
    input wire logic fifo_empty,
    output logic [9:0] tx_word,
    output logic fifo_rd,
    output logic [7:0] pop_count
);
    // Word launched at the clock edge
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tx_word <= '0;
        end else begin
            tx_word <= word_req;
        end
    end
    // Read enable level, every other cycle when slow
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            fifo_rd <= 1'b0;
        end else begin
            fifo_rd <= drain_req & (~slow_rd | ~fifo_rd);
        end
    end
    // Count words really popped
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pop_count <= 8'h00;
        end else if (fifo_rd && !fifo_empty) begin
            pop_count <= pop_count + 8'h01;
        end
    end
endmodule : core_logic_model

// File: test/fast_io_lane_test.sv
// Self-checking bench for the fast I/O lane on one clock.
// Assumes tx pads loop back to rx pads; the core model feeds words and reads.
`timescale 1ns/100ps
module fast_io_lane_test;
    import lane_pkg::*;
    // Register table row: write, readback, {oe,buf,term}, bad lanes
    typedef struct packed {
        logic [31:0] wr;
        logic [31:0] rd;
        logic [2:0] pins;
        logic bad;
    } reg_row_t;
    logic ref_clk = 1'b0, nrst = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic wb_ack_o, fifo_empty, fifo_rd, phase_lock, tx_pad_p, tx_pad_n, tx_pad_oe;
    logic tx_path_reset = 1'b0, rx_path_reset = 1'b0, drain_req = 1'b0, slow_rd = 1'b1;
    logic delay_adjust_enable = 1'b0, delay_step_up = 1'b0, delay_adjust_reset = 1'b0;
    logic rx_buffer_on, rx_term_on, fwd_serial_en, fwd_parallel_en;
    logic [9:0] tx_word, rx_word, fifo_word, word_req = 10'h0a5;
    logic [5:0] final_delay_setting;
    logic [7:0] pop_count;
    int err_total = 0, cmp_count = 0;
    reg_row_t rows [7] = '{
        '{32'h00018d01, 32'h00018d01, 3'b111, 1'b0}, '{32'hffff0d00, 32'h00010d00, 3'b100, 1'b0},
        '{32'h00008d00, 32'h00008d00, 3'b010, 1'b0}, '{32'h00000d01, 32'h00000d01, 3'b001, 1'b0},
        '{32'h00001d00, 32'h00001d00, 3'b000, 1'b1}, '{32'h00001500, 32'h00001500, 3'b000, 1'b0},
        '{32'h00004500, 32'h00004500, 3'b000, 1'b0}};
    // Pads looped back, differential pair kept intact
    wire logic rx_pad_p = tx_pad_p;
    wire logic rx_pad_n = tx_pad_n;
    // Clock at 100 ns period
    always #50 ref_clk = ~ref_clk;
    fast_io_lane #(.LOCK_WORDS(2)) u_dut (.ref_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .tx_word, .tx_path_reset, .rx_word,
        .fifo_word, .fifo_empty, .fifo_rd, .rx_path_reset, .phase_lock, .final_delay_setting,
        .delay_adjust_enable, .delay_step_up, .delay_adjust_reset, .rx_pad_p, .rx_pad_n, .tx_pad_p,
        .tx_pad_n, .tx_pad_oe, .rx_buffer_on, .rx_term_on, .fwd_serial_en, .fwd_parallel_en);
    core_logic_model u_core (.ref_clk, .nrst, .word_req, .drain_req, .slow_rd, .fifo_empty,
        .tx_word, .fifo_rd, .pop_count);
    // Word comparison
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask : check_word
    // Flag comparison
    task automatic check_flag(input logic got, input logic exp);
        check_word({31'h0, got}, {31'h0, exp});
    endtask : check_flag
    // One classic Wishbone cycle, held until ack
    task automatic wb_io(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                         input logic [31:0] dat, output logic [31:0] rdat);
        int n;
        n = 0;
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        check_flag(wb_ack_o, 1'b1);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : wb_io
    // Wait for a visible parallel-word edge; a missing one is a mismatch
    task automatic wait_par(input int cnt);
        int n;
        for (int k = 0; k < cnt; k++) begin
            n = 0;
            do begin
                @(posedge ref_clk);
                n++;
            end while (fwd_parallel_en !== 1'b1 && n < 40);
            check_flag(fwd_parallel_en, 1'b1);
        end
    endtask : wait_par
    // Is w an eight-bit rotation of v
    function automatic logic is_rot(input logic [9:0] w, input logic [7:0] v);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (w === {2'b00, v}) hit = 1'b1;
            v = {v[0], v[7:1]};
        end
        return hit;
    endfunction : is_rot
    // Counts, verdict and end of run
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict
    // Watchdog well past the expected run
    initial begin
        #2000000;
        err_total++;
        give_verdict();
    end
    // Main sequence
    initial begin
        logic [31:0] r;
        logic [5:0] f;
        logic [9:0] g;
        int n;
        repeat (6) @(posedge ref_clk);
        check_word({tx_pad_p, tx_pad_n, fifo_empty, phase_lock}, 32'h6);
        nrst <= 1'b1;
        wb_io(1'b0, CTRL_OFS, 4'hf, 32'h0, r);
        check_word(r, 32'h00000d00);
        wb_io(1'b0, STATUS_OFS, 4'hf, 32'h0, r);
        check_word(r, 32'h00000002);
        foreach (rows[i]) begin
            wb_io(1'b1, CTRL_OFS, 4'hf, rows[i].wr, r);
            wb_io(1'b0, CTRL_OFS, 4'hf, 32'h0, r);
            check_word(r, rows[i].rd);
            check_word({tx_pad_oe, rx_buffer_on, rx_term_on}, rows[i].pins);
            wb_io(1'b0, STATUS_OFS, 4'hf, 32'h0, r);
            check_flag(r[2], rows[i].bad);
        end
        wb_io(1'b1, CTRL_OFS, 4'h1, 32'h0, r);
        wb_io(1'b0, CTRL_OFS, 4'hf, 32'h0, r);
        check_word(r, 32'h00004500);
        wb_io(1'b0, 8'h08, 4'hf, 32'h0, r);
        check_word(r, 32'h0);
        $display("register test done");
        wb_io(1'b1, CTRL_OFS, 4'hf, 32'h00018d28, r);
        wait_par(2);
        for (int k = 0; k < 8; k++) begin
            @(posedge ref_clk);
            check_word({tx_pad_p, tx_pad_n}, {word_req[k], ~word_req[k]});
        end
        check_flag(fwd_parallel_en, 1'b1);
        wait_par(3);
        check_flag(is_rot(rx_word, word_req[7:0]), 1'b1);
        wb_io(1'b1, CTRL_OFS, 4'hf, 32'h00018d68, r);
        wait_par(2);
        for (int k = 0; k < 8; k++) begin
            @(posedge ref_clk);
            check_flag(tx_pad_p, k < 4);
        end
        $display("serializer test done");
        wb_io(1'b1, CTRL_OFS, 4'hf, 32'h00018d28, r);
        tx_path_reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        r = 32'h0;
        repeat (16) @(posedge ref_clk) r[0] = r[0] | (tx_pad_p !== 1'b0);
        check_flag(r[0], 1'b0);
        tx_path_reset <= 1'b0;
        $display("transmit reset test done");
        wb_io(1'b1, CTRL_OFS, 4'hf, 32'h00018d2a, r);
        delay_adjust_enable <= 1'b1;
        delay_step_up <= 1'b1;
        for (n = 0; n < 300 && phase_lock !== 1'b1; n++) @(posedge ref_clk);
        check_flag(phase_lock, 1'b1);
        // Final setting follows the lock by one cycle
        @(posedge ref_clk);
        f = final_delay_setting;
        wb_io(1'b0, STATUS_OFS, 4'hf, 32'h0, r);
        check_word({r[8:3], r[0]}, {f, 1'b1});
        wait_par(3);
        check_word(final_delay_setting, f);
        delay_adjust_reset <= 1'b1;
        wait_par(2);
        @(posedge ref_clk);
        check_word({phase_lock, final_delay_setting}, 32'h0);
        delay_adjust_reset <= 1'b0;
        delay_adjust_enable <= 1'b0;
        // Eight manual steps up delay the sampled stream by one bit
        wb_io(1'b1, CTRL_OFS, 4'hf, 32'h00018d28, r);
        wait_par(2);
        g = rx_word;
        delay_adjust_enable <= 1'b1;
        wait_par(8);
        delay_adjust_enable <= 1'b0;
        wait_par(2);
        check_word(rx_word, {g[6:0], g[7]});
        $display("alignment test done");
        wb_io(1'b1, CTRL_OFS, 4'hf, 32'h00018d2c, r);
        wait_par(10);
        wb_io(1'b1, CTRL_OFS, 4'hf, 32'h00018d28, r);
        wb_io(1'b0, STATUS_OFS, 4'hf, 32'h0, r);
        check_word({r[12:9], r[1]}, {4'h8, 1'b0});
        drain_req <= 1'b1;
        for (n = 0; n < 100 && fifo_empty !== 1'b1; n++) @(posedge ref_clk);
        drain_req <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check_word({fifo_empty, pop_count}, {1'b1, 8'h08});
        check_flag(is_rot(fifo_word, word_req[7:0]), 1'b1);
        wb_io(1'b1, CTRL_OFS, 4'hf, 32'h00018d2c, r);
        wait_par(3);
        check_flag(fifo_empty, 1'b0);
        @(posedge ref_clk);
        rx_path_reset <= 1'b1;
        #1;
        check_word({fifo_empty, rx_word}, 32'h400);
        @(posedge ref_clk);
        rx_path_reset <= 1'b0;
        $display("fifo test done");
        wb_io(1'b1, CTRL_OFS, 4'hf, 32'h00018d30, r);
        repeat (20) @(posedge ref_clk);
        check_word({fwd_serial_en, rx_word}, {1'b0, 9'h000, word_req[0]});
        $display("low power test done");
        give_verdict();
    end
endmodule : fast_io_lane_test
